/* File: bsr_device.sv */
`timescale 1ns/1ns
// Operation
// [RULE1] 20h command echoed, starts checksum reply
// [RULE2] receive error answered with low nibble 8
// [RULE3] error ack upper nibble from last command
// [RULE4] known command echoed unchanged
// [RULE5] unknown command answered with low nibble 1
// [RULE6] sum sent upper byte, then lower byte
// [RULE7] seventh byte negates sum of sum bytes
// [RULE8] controller sends next command after reply
// [RULE9] 30h command echoed, starts information reply
// [RULE10] bytes 5-8 are software identification bytes
// [RULE11] bytes 9-20 are space padded part name
// [RULE12] bytes 21-24 password compare start address
// [RULE13] bytes 25-36 three ram addresses
// [RULE14] bytes 37-44 are filler
// [RULE15] bytes 45-46 are protection status word
// [RULE16] bytes 47-50 flash start address
// [RULE17] bytes 51-54 flash end address
// [RULE18] bytes 55-56 sector count
// [RULE19] bytes 57-65 sector description
// [RULE20] byte 66 negates sum of bytes 5-65
// [RULE21] 40h command echoed, then await confirmation
// [RULE22] 54h confirms erase, else command error
// [RULE23] erase result byte then completion ack
// [RULE24] bytes handled one at a time
module bsr_device
    import bsr_pkg::*;
#(
    parameter logic [95:0] PART_NAME = PART_NAME_DEF
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // link to the controller
    bsr_if.dev link,
    // flash facts
    input wire logic [15:0] flash_sum_i,
    input wire logic [31:0] sw_id_i,
    input wire logic read_prot_i,
    input wire logic write_prot_i,
    // erase engine
    input wire logic erase_done_i,
    input wire logic erase_ok_i,
    output logic erase_start_o,
    output logic cmd_idle_o
);
    typedef enum logic [6:0] {
        S_CMD = 7'b0000001,
        S_ACK = 7'b0000010,
        S_SUM = 7'b0000100,
        S_INFO = 7'b0001000,
        S_CONF = 7'b0010000,
        S_ERASE = 7'b0100000,
        S_RES = 7'b1000000
    } bsr_state_e;

    bsr_state_e state_q;
    bsr_state_e state_d;
    bsr_state_e next_q;
    logic [7:0] ack_q;
    logic [7:0] last_cmd_q;
    logic [6:0] idx_q;
    logic [7:0] cks_q;
    logic erase_ok_q;
    logic ready_q;
    logic erase_start_q;
    logic idle_q;
    logic accept;
    logic push_req;
    logic push;
    logic [7:0] push_byte;
    logic [7:0] info_byte;
    logic fifo_free;
    logic pop;
    logic [7:0] buf_q [BUF_DEPTH];
    logic wr_q;
    logic rd_q;
    logic [1:0] cnt_q;

    assign accept = link.c2d_valid & ready_q; // [RULE24]
    assign fifo_free = (cnt_q != 2'(BUF_DEPTH));
    assign push = push_req & fifo_free;
    assign pop = link.d2c_valid & link.d2c_ready;
    assign link.c2d_ready = ready_q;
    assign link.d2c_valid = (cnt_q != 2'h0);
    assign link.d2c_data = buf_q[rd_q];
    assign erase_start_o = erase_start_q;
    assign cmd_idle_o = idle_q;

    // information reply byte at the current index
    always_comb begin // [RULE18] [RULE19]
        int k;
        k = int'(idx_q);
        info_byte = 8'h00;
        if (k < INFO_BYTES) begin // [RULE12] [RULE13] [RULE14] [RULE16]
            info_byte = INFO_TABLE[8*(INFO_BYTES-1-k) +: 8]; // [RULE17]
        end
        if (k >= ID_POS && k < ID_POS + ID_LEN) begin
            info_byte = sw_id_i[8*(k-ID_POS) +: 8]; // [RULE10]
        end
        if (k >= NAME_POS && k < NAME_POS + NAME_LEN) begin
            info_byte = PART_NAME[8*(NAME_POS+NAME_LEN-1-k) +: 8]; // [RULE11]
        end
        if (k == STAT_POS) begin
            info_byte[STAT_READ_BIT] = ~read_prot_i; // [RULE15]
            info_byte[STAT_WRITE_BIT] = ~write_prot_i; // [RULE15]
            info_byte[STAT_SECTOR_BIT] = STAT_SECTORED; // [RULE15]
        end
    end

    // sequencer
    always_comb begin
        state_d = state_q;
        push_req = 1'b0;
        push_byte = 8'h00;
        case (state_q)
            S_CMD, S_CONF: begin
                if (accept) begin
                    state_d = S_ACK;
                end
            end
            S_ACK: begin
                push_req = 1'b1;
                push_byte = ack_q;
                if (fifo_free) begin
                    state_d = next_q;
                end
            end
            S_SUM: begin
                push_req = 1'b1;
                if (idx_q == 7'h00) begin
                    push_byte = flash_sum_i[15:8]; // [RULE6]
                end else if (idx_q == 7'h01) begin
                    push_byte = flash_sum_i[7:0]; // [RULE6]
                end else begin
                    push_byte = 8'h00 - cks_q; // [RULE7]
                end
                if (fifo_free && idx_q == SUM_LAST) begin
                    state_d = S_CMD;
                end
            end
            S_INFO: begin
                push_req = 1'b1;
                if (idx_q == INFO_LAST) begin
                    push_byte = 8'h00 - cks_q; // [RULE20]
                end else begin
                    push_byte = info_byte;
                end
                if (fifo_free && idx_q == INFO_LAST) begin
                    state_d = S_CMD;
                end
            end
            S_ERASE: begin
                if (erase_done_i) begin
                    state_d = S_RES;
                end
            end
            S_RES: begin
                push_req = 1'b1;
                if (idx_q == 7'h00) begin
                    push_byte = erase_ok_q ? END_OK : END_FAIL; // [RULE23]
                end else begin
                    push_byte = erase_ok_q ? ACK_ERASE_OK
                        : ACK_ERASE_FAIL; // [RULE23]
                end
                if (fifo_free && idx_q == RES_LAST) begin
                    state_d = S_CMD;
                end
            end
            default: begin
                state_d = S_CMD;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_q <= S_CMD;
        end else begin
            state_q <= state_d;
        end
    end

    // command and confirmation decode
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ack_q <= 8'h00;
            next_q <= S_CMD;
            last_cmd_q <= LAST_CMD_RST;
        end else if (accept && state_q == S_CMD) begin
            if (link.c2d_err) begin
                ack_q <= {last_cmd_q[7:4], NIB_RX_ERR}; // [RULE2] [RULE3]
                next_q <= S_CMD;
            end else begin
                last_cmd_q <= link.c2d_data;
                ack_q <= link.c2d_data; // [RULE4]
                case (link.c2d_data)
                    CMD_SUM: next_q <= S_SUM; // [RULE1]
                    CMD_INFO: next_q <= S_INFO; // [RULE9]
                    CMD_ERASE: next_q <= S_CONF; // [RULE21]
                    default: begin // [RULE5]
                        ack_q <= {link.c2d_data[7:4], NIB_CMD_ERR}; // [RULE3]
                        next_q <= S_CMD;
                    end
                endcase
            end
        end else if (accept) begin
            if (link.c2d_err) begin
                ack_q <= {last_cmd_q[7:4], NIB_RX_ERR}; // [RULE2] [RULE3]
                next_q <= S_CMD;
            end else if (link.c2d_data == ERASE_CONFIRM) begin
                ack_q <= ERASE_CONFIRM; // [RULE22]
                next_q <= S_ERASE;
            end else begin
                ack_q <= {last_cmd_q[7:4], NIB_CMD_ERR}; // [RULE22] [RULE3]
                next_q <= S_CMD;
            end
        end
    end

    // reply index and running checksum
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            idx_q <= 7'h00;
            cks_q <= 8'h00;
        end else if (state_q == S_ACK || state_q == S_ERASE) begin
            idx_q <= 7'h00;
            cks_q <= 8'h00;
        end else if (push) begin
            idx_q <= idx_q + 7'h01;
            cks_q <= cks_q + push_byte; // [RULE7] [RULE20]
        end
    end

    // erase handshake and status flops
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            erase_start_q <= 1'b0;
            erase_ok_q <= 1'b0;
            ready_q <= 1'b0;
            idle_q <= 1'b0;
        end else begin
            erase_start_q <= (state_q == S_ACK) && fifo_free
                && (next_q == S_ERASE); // [RULE22]
            if (state_q == S_ERASE && erase_done_i) begin
                erase_ok_q <= erase_ok_i;
            end
            ready_q <= (state_d == S_CMD) || (state_d == S_CONF); // [RULE24]
            idle_q <= (state_d == S_CMD);
        end
    end

    // two-entry reply buffer
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clock_i) begin
        if (push) begin
            buf_q[wr_q] <= push_byte;
        end
    end
endmodule

/* File: bsr_pkg.sv */
package bsr_pkg;
    // operation command bytes and their echoes
    localparam logic [7:0] CMD_SUM = 8'h20;
    localparam logic [7:0] CMD_INFO = 8'h30;
    localparam logic [7:0] CMD_ERASE = 8'h40;
    localparam logic [7:0] ERASE_CONFIRM = 8'h54;
    // erase result and completion acknowledges
    localparam logic [7:0] END_OK = 8'h4f;
    localparam logic [7:0] END_FAIL = 8'h4c;
    localparam logic [7:0] ACK_ERASE_OK = 8'h5d;
    localparam logic [7:0] ACK_ERASE_FAIL = 8'h60;
    // error acknowledge low nibbles
    localparam logic [3:0] NIB_RX_ERR = 4'h8;
    localparam logic [3:0] NIB_CMD_ERR = 4'h1;
    // reset value of the remembered command byte
    localparam logic [7:0] LAST_CMD_RST = 8'h00;
    // reply last indices and lengths after the acknowledge, checksum included
    localparam logic [6:0] SUM_LAST = 7'h02;
    localparam logic [6:0] INFO_LAST = 7'h3d;
    localparam logic [6:0] RES_LAST = 7'h01;
    localparam logic [6:0] SUM_REPLY_LEN = 7'h03;
    localparam logic [6:0] INFO_REPLY_LEN = 7'h3e;
    localparam logic [6:0] ERASE_REPLY_LEN = 7'h02;
    // positions inside the information reply (0 is the fifth byte)
    localparam int INFO_BYTES = 61;
    localparam int ID_POS = 0;
    localparam int ID_LEN = 4;
    localparam int NAME_POS = 4;
    localparam int NAME_LEN = 12;
    localparam int STAT_POS = 40;
    // status word bits
    localparam int STAT_READ_BIT = 0;
    localparam int STAT_WRITE_BIT = 1;
    localparam int STAT_SECTOR_BIT = 2;
    localparam logic STAT_SECTORED = 1'b0;
    // arbitrary neutral part designation, space padded
    localparam logic [95:0] PART_NAME_DEF = "BSRPART01   ";
    // fixed information bytes, first byte in the top lane
    localparam logic [8*INFO_BYTES-1:0] INFO_TABLE = {
        32'h00000000, // identification, filled live
        96'h0, // part name, filled live
        32'hf4fe0200, // password compare start
        32'h00100000, // ram start
        32'hff2d0000, // ram user area end
        32'hff2f0000, // ram end
        64'h0, // filler
        16'h0000, // status, filled live
        32'h00000100, // flash start
        32'hffff0200, // flash end
        16'h1000, // sector count
        32'h00000100, // sector start
        24'h001000, // sector size in words
        16'h1000 // equal sectors
    };
    // reply buffer depth
    localparam int BUF_DEPTH = 2;
endpackage

/* File: bsr_if.sv */
`timescale 1ns/1ns
interface bsr_if;
    // controller to device byte stream
    logic c2d_valid;
    logic [7:0] c2d_data;
    logic c2d_err;
    logic c2d_ready;
    // device to controller byte stream
    logic d2c_valid;
    logic [7:0] d2c_data;
    logic d2c_ready;

    modport dev (
        input c2d_valid, c2d_data, c2d_err, d2c_ready,
        output c2d_ready, d2c_valid, d2c_data
    );
    modport ctl (
        output c2d_valid, c2d_data, c2d_err, d2c_ready,
        input c2d_ready, d2c_valid, d2c_data
    );
endinterface

/* File: bsr_ctrl.sv */
`timescale 1ns/1ns
module bsr_ctrl
    import bsr_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // link to the device
    bsr_if.ctl link,
    // byte requests from the user
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_byte_i,
    input wire logic cmd_err_i,
    output logic cmd_ready_o,
    // reply bytes to the user
    output logic reply_valid_o,
    output logic [7:0] reply_byte_o
);
    logic drv_valid_q;
    logic [7:0] drv_data_q;
    logic drv_err_q;
    logic rdy_q;
    logic ack_phase_q;
    logic [6:0] rem_q;
    logic d2c_ready_q;
    logic reply_valid_q;
    logic [7:0] reply_byte_q;

    assign link.c2d_valid = drv_valid_q;
    assign link.c2d_data = drv_data_q;
    assign link.c2d_err = drv_err_q;
    assign link.d2c_ready = d2c_ready_q;
    assign cmd_ready_o = rdy_q;
    assign reply_valid_o = reply_valid_q;
    assign reply_byte_o = reply_byte_q;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            drv_valid_q <= 1'b0;
            drv_data_q <= 8'h00;
            drv_err_q <= 1'b0;
            rdy_q <= 1'b0;
            ack_phase_q <= 1'b0;
            rem_q <= 7'h00;
            d2c_ready_q <= 1'b0;
            reply_valid_q <= 1'b0;
            reply_byte_q <= 8'h00;
        end else begin
            d2c_ready_q <= 1'b1;
            reply_valid_q <= 1'b0;
            if (!rdy_q && !drv_valid_q && !ack_phase_q && rem_q == 7'h00
                && !(link.d2c_valid && d2c_ready_q)) begin
                rdy_q <= 1'b1;
            end
            if (cmd_valid_i && rdy_q) begin
                drv_valid_q <= 1'b1; // [RULE24]
                drv_data_q <= cmd_byte_i;
                drv_err_q <= cmd_err_i;
                rdy_q <= 1'b0;
            end
            if (drv_valid_q && link.c2d_ready) begin
                drv_valid_q <= 1'b0;
                ack_phase_q <= 1'b1;
            end
            if (link.d2c_valid && d2c_ready_q) begin
                reply_valid_q <= 1'b1;
                reply_byte_q <= link.d2c_data;
                if (ack_phase_q) begin
                    ack_phase_q <= 1'b0;
                    case (link.d2c_data)
                        CMD_SUM: rem_q <= SUM_REPLY_LEN; // [RULE1]
                        CMD_INFO: rem_q <= INFO_REPLY_LEN; // [RULE9]
                        CMD_ERASE: rem_q <= 7'h00; // [RULE21]
                        ERASE_CONFIRM: rem_q <= ERASE_REPLY_LEN; // [RULE22]
                        default: rem_q <= 7'h00;
                    endcase
                end else if (rem_q != 7'h00) begin
                    rem_q <= rem_q - 7'h01; // [RULE8]
                end
            end
        end
    end
endmodule

/* File: bsr_properties.sv */
`timescale 1ns/1ns
module bsr_properties
    import bsr_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // link signals
    input wire logic c2d_valid,
    input wire logic [7:0] c2d_data,
    input wire logic c2d_err,
    input wire logic c2d_ready,
    input wire logic d2c_valid,
    input wire logic [7:0] d2c_data,
    input wire logic d2c_ready
);
    logic take;
    logic fresh;
    logic known;
    logic conf_q;
    logic [7:0] last_q;
    assign take = c2d_valid && c2d_ready;
    assign fresh = take && !d2c_valid;
    assign known = c2d_data inside {CMD_SUM, CMD_INFO, CMD_ERASE};
    // awaiting the erase confirmation
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            conf_q <= 1'b0;
        end else if (take) begin
            conf_q <= !conf_q && !c2d_err && c2d_data == CMD_ERASE;
        end
    end
    // last clean operation command
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            last_q <= LAST_CMD_RST;
        end else if (take && !c2d_err && !conf_q) begin
            last_q <= c2d_data;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    ready_drop_a: assert property (take |=> !c2d_ready)
        else $error("ready stayed high after a take");
    ack_gap_a: assert property (fresh |=> !d2c_valid)
        else $error("ack came too early");
    ack_due_a: assert property (take |-> ##[2:3] d2c_valid)
        else $error("ack missing");
    rx_err_low_a: assert property (fresh && c2d_err |->
        ##2 d2c_valid && d2c_data[3:0] == NIB_RX_ERR)
        else $error("bad receive error nibble");
    rx_err_high_a: assert property (fresh && c2d_err |->
        ##2 {d2c_data[7:4], 4'h0} == ($past(last_q, 2) & 8'hf0))
        else $error("bad error ack upper nibble");
    echo_known_a: assert property (fresh && !c2d_err
        && !conf_q && known |-> ##2 d2c_data == $past(c2d_data, 2))
        else $error("command not echoed");
    unknown_cmd_a: assert property (fresh && !c2d_err
        && !conf_q && !known |-> ##2 d2c_data[3:0] == NIB_CMD_ERR
        && {d2c_data[7:4], 4'h0} == ($past(c2d_data, 2) & 8'hf0))
        else $error("bad command error ack");
    confirm_ok_a: assert property (fresh && !c2d_err && conf_q
        && c2d_data == ERASE_CONFIRM |-> ##2 d2c_data == ERASE_CONFIRM)
        else $error("confirmation not echoed");
    confirm_bad_a: assert property (fresh && !c2d_err && conf_q
        && c2d_data != ERASE_CONFIRM |-> ##2 d2c_data == 8'h41)
        else $error("bad confirmation ack");
endmodule

/* File: bsr_bench.sv */
`timescale 1ns/1ns
module bsr_bench
    import bsr_pkg::*;
;
    localparam logic [127:0] MID = 128'hf4fe0200_00100000_ff2d0000_ff2f0000;
    localparam logic [151:0] TAIL =
        152'h00000100_ffff0200_1000_00000100_001000_1000;
    localparam logic [9:0] PLAN [12] = '{10'h020, 10'h030, 10'h040, 10'h154,
        10'h040, 10'h054, 10'h040, 10'h055, 10'h040, 10'h220, 10'h0a7,
        10'h233};
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] flash_sum = 16'h0000;
    logic [31:0] sw_id = 32'h0;
    logic read_prot = 1'b0;
    logic write_prot = 1'b0;
    logic erase_done = 1'b0;
    logic erase_ok = 1'b0;
    logic erase_start;
    logic cmd_idle;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_byte = 8'h00;
    logic cmd_err = 1'b0;
    logic cmd_ready;
    logic reply_valid;
    logic [7:0] reply_byte;
    logic [7:0] expq[$];
    logic [7:0] rxq[$];
    logic [7:0] last = 8'h00;
    logic [7:0] acc;
    logic [7:0] b;
    logic conf = 1'b0;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    bsr_if link_if();
    bsr_device bsr_device_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .link(link_if), .flash_sum_i(flash_sum), .sw_id_i(sw_id),
        .read_prot_i(read_prot), .write_prot_i(write_prot),
        .erase_done_i(erase_done), .erase_ok_i(erase_ok),
        .erase_start_o(erase_start), .cmd_idle_o(cmd_idle));
    bsr_ctrl bsr_ctrl_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .link(link_if), .cmd_valid_i(cmd_valid), .cmd_byte_i(cmd_byte),
        .cmd_err_i(cmd_err), .cmd_ready_o(cmd_ready),
        .reply_valid_o(reply_valid), .reply_byte_o(reply_byte));
    bsr_properties bsr_properties_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .c2d_valid(link_if.c2d_valid), .c2d_data(link_if.c2d_data),
        .c2d_err(link_if.c2d_err), .c2d_ready(link_if.c2d_ready),
        .d2c_valid(link_if.d2c_valid), .d2c_data(link_if.d2c_data),
        .d2c_ready(link_if.d2c_ready));
    always #5 clock_i = ~clock_i;
    // erase engine answers one cycle after the start pulse
    always @(posedge clock_i) begin
        erase_done <= #1 erase_start;
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    always @(negedge clock_i) begin
        if (reply_valid === 1'b1) begin
            rxq.push_back(reply_byte);
        end
    end
    task step;
        @(posedge clock_i);
        #1;
    endtask
    task give_verdict;
        if (n_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task put(input logic [7:0] v);
        expq.push_back(v);
        acc = acc + v;
    endtask
    task send(input logic [7:0] v, input logic e);
        acc = 8'h00;
        if (e) begin
            put({last[7:4], NIB_RX_ERR});
            conf = 1'b0;
        end else if (conf) begin
            conf = 1'b0;
            if (v == ERASE_CONFIRM) begin
                put(v);
                put(erase_ok ? END_OK : END_FAIL);
                put(erase_ok ? ACK_ERASE_OK : ACK_ERASE_FAIL);
            end else begin
                put(8'h41);
            end
        end else begin
            last = v;
            if (v == CMD_SUM) begin
                put(v);
                acc = 8'h00;
                put(flash_sum[15:8]);
                put(flash_sum[7:0]);
                put(8'h00 - acc);
            end else if (v == CMD_INFO) begin
                put(v);
                acc = 8'h00;
                for (int i = 0; i < 4; i++) put(sw_id[8*i +: 8]);
                for (int i = 0; i < 12; i++) begin
                    put(PART_NAME_DEF[95-8*i -: 8]);
                end
                for (int i = 0; i < 16; i++) begin
                    put(MID[127-8*i -: 8]);
                end
                for (int i = 0; i < 8; i++) put(8'h00);
                put({6'h00, ~write_prot, ~read_prot});
                put(8'h00);
                for (int i = 0; i < 19; i++) begin
                    put(TAIL[151-8*i -: 8]);
                end
                put(8'h00 - acc);
            end else if (v == CMD_ERASE) begin
                put(v);
                conf = 1'b1;
            end else begin
                put({v[7:4], NIB_CMD_ERR});
            end
        end
        cmd_valid = 1'b1;
        cmd_byte = v;
        cmd_err = e;
        while (cmd_ready !== 1'b1) step;
        step;
        cmd_valid = 1'b0;
        while (rxq.size() < expq.size() || cmd_ready !== 1'b1) step;
        check({7'h00, cmd_idle}, {7'h00, !conf});
        while (expq.size() > 0) begin
            check(rxq.pop_front(), expq.pop_front());
        end
    endtask
    initial begin
        void'($urandom(32'h7c6885d6));
        repeat (12) @(posedge clock_i);
        #1;
        rst_n_i = 1'b1;
        flash_sum = 16'($urandom);
        sw_id = $urandom;
        read_prot = 1'($urandom);
        write_prot = 1'($urandom);
        send(CMD_SUM, 1'b1);
        for (int i = 0; i < 12; i++) begin
            erase_ok = PLAN[i][8];
            send(PLAN[i][7:0], PLAN[i][9]);
        end
        for (int i = 0; i < 60; i++) begin
            case ($urandom % 4)
                0: b = CMD_SUM;
                1: b = CMD_INFO;
                2: b = conf ? ERASE_CONFIRM : CMD_ERASE;
                default: b = 8'($urandom);
            endcase
            if (b == 8'h10 || b == 8'h60) begin
                b = CMD_INFO;
            end
            erase_ok = 1'($urandom);
            flash_sum = 16'($urandom);
            sw_id = $urandom;
            read_prot = 1'($urandom);
            write_prot = 1'($urandom);
            send(b, ($urandom % 6) == 0);
        end
        give_verdict();
    end
endmodule
